/* File: verilog/rf_gain_pkg.sv */
// Constants shared by the Rf_link_status and receive-gain control register bank.
// Assumes 32-bit APB data and one register per aligned word.
`default_nettype none
package rf_gain_pkg;

    // ****************************************
    // Register indices; byte address = 4 * index
    // ****************************************
    localparam logic [7:0]  IDX_RF_LINK_STATUS      = 8'h1D;
    localparam logic [7:0]  IDX_GAIN_CONTROL_CONFIG = 8'h1E;
    localparam logic [7:0]  IDX_STATIC_GAIN         = 8'h1F;
    localparam logic [7:0]  IDX_FIELD_DRIVE_CTRL    = 8'h30;
    localparam int          ADDR_W                  = 12;
    localparam int          ADDR_LSB                = 2;

    // ****************************************
    // Status word fields
    // ****************************************
    localparam int          ST_PHASE_LSB            = 24;
    localparam int          ST_STEP_LSB             = 20;
    localparam int          ST_LOCK_BIT             = 19;
    localparam int          ST_CRC_OK_BIT           = 18;
    localparam int          ST_OWN_FIELD_BIT        = 17;
    localparam int          ST_EXT_FIELD_BIT        = 16;
    localparam int          ST_FAULT_LSB            = 13;
    localparam int          ST_RX_ARMED_BIT         = 12;
    localparam int          ST_TX_BUSY_BIT          = 11;
    localparam int          ST_RX_BUSY_BIT          = 10;
    localparam int          ST_GAIN_LSB             = 0;

    // ****************************************
    // Configuration word fields
    // ****************************************
    localparam int          CF_SETPOINT_LSB         = 14;
    localparam int          CF_PERIOD_LSB           = 4;
    localparam int          CF_SOURCE_BIT           = 3;
    localparam int          CF_LOAD_BIT             = 2;
    localparam int          CF_CHOICE_BIT           = 1;
    localparam int          CF_LOOP_ON_BIT          = 0;

    // ****************************************
    // Static gain and field drive word fields
    // ****************************************
    localparam int          SG_READER_LSB           = 10;
    localparam int          SG_CARD_LSB             = 0;
    localparam int          FD_REQUEST_BIT          = 0;

    // ****************************************
    // Widths, encodings and reset values
    // ****************************************
    localparam int          GAIN_W                  = 10;
    localparam int          PERIOD_W                = 10;
    localparam logic [2:0]  PHASE_IDLE              = 3'h0;
    localparam logic [2:0]  FAULT_NONE              = 3'h0;
    localparam logic [2:0]  FAULT_FIRST             = 3'h1;
    localparam logic [2:0]  FAULT_LAST              = 3'h4;
    localparam logic [1:0]  SETPOINT_RESET          = 2'h0;
    localparam logic [9:0]  GAIN_RESET              = 10'h000;
    localparam logic [9:0]  GAIN_MAX                = 10'h3FF;
    localparam logic [9:0]  PERIOD_RESET            = 10'h000;
    localparam logic [31:0] WORD_ZERO               = 32'h0000_0000;

endpackage
`default_nettype wire

/* File: verilog/rf_link_status_gain_ctrl.sv */
// RF link status word and receive-gain control loop behind an APB slave.
// Assumes status sources on CLK_I except the RF clock, detector and comparator pins.
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`default_nettype none

module rf_link_status_gain_ctrl
    import rf_gain_pkg::*;
#(
    parameter int              CRC_W          = 16,
    parameter logic [15:0]     CRC_RESIDUE    = 16'h0000,
    parameter int              EXT_FILTER_LEN = 4
) (
    input  wire logic          CLK_I,
    input  wire logic          RST_B_I,
    input  wire logic          PSEL_I,
    input  wire logic          PENABLE_I,
    input  wire logic          PWRITE_I,
    input  wire logic [11:0]   PADDR_I,
    input  wire logic [31:0]   PWDATA_I,
    output logic      [31:0]   PRDATA_O,
    output logic               PREADY_O,
    output logic               PSLVERR_O,
    input  wire logic [2:0]    TRX_PHASE_I,
    input  wire logic [3:0]    POWER_STEP_I,
    input  wire logic          RF_ON_I,
    input  wire logic          RF_FREQ_OK_I,
    input  wire logic          PLL_LOCKED_I,
    input  wire logic [15:0]   CRC_VALUE_I,
    input  wire logic          CRC_INVERTED_I,
    input  wire logic          DRIVERS_ON_I,
    input  wire logic          EXT_FIELD_RAW_I,
    input  wire logic          PEER_FAULT_VALID_I,
    input  wire logic [2:0]    PEER_FAULT_CODE_I,
    input  wire logic          RX_DECODER_READY_I,
    input  wire logic          TX_ENCODER_BUSY_I,
    input  wire logic          RX_DECODER_BUSY_I,
    input  wire logic          CLK_RF_I,
    input  wire logic          RX_ABOVE_SETPOINT_I,
    output logic      [1:0]    GAIN_SETPOINT_SEL_O,
    output logic      [9:0]    RX_DIVIDER_O,
    output logic               FIELD_DRIVER_ON_REQUEST_O
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (CRC_W < 1 || CRC_W > 16) begin : g_bad_crc
        $error("CRC_W must lie in 1..16");
    end
    if (EXT_FILTER_LEN < 1 || EXT_FILTER_LEN > 255) begin : g_bad_filter
        $error("EXT_FILTER_LEN must lie in 1..255");
    end

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
        hit = (addr[ADDR_LSB-1:0] == 2'b00) && (addr[ADDR_W-1:ADDR_LSB] == {2'b00, idx});
    endfunction

    logic                 setup_phase;
    logic                 access_phase;
    logic                 wr_cfg;
    logic                 wr_static;
    logic                 wr_drive;
    logic                 mapped;

    assign setup_phase  = PSEL_I && !PENABLE_I;
    assign access_phase = PSEL_I && PENABLE_I;
    assign mapped       = hit(PADDR_I, IDX_RF_LINK_STATUS) || hit(PADDR_I, IDX_GAIN_CONTROL_CONFIG)
                       || hit(PADDR_I, IDX_STATIC_GAIN) || hit(PADDR_I, IDX_FIELD_DRIVE_CTRL);
    // Zero wait states: every access completes in its first access cycle
    assign PREADY_O     = 1'b1;
    assign wr_cfg       = access_phase && PWRITE_I && hit(PADDR_I, IDX_GAIN_CONTROL_CONFIG);
    assign wr_static    = access_phase && PWRITE_I && hit(PADDR_I, IDX_STATIC_GAIN);
    assign wr_drive     = access_phase && PWRITE_I && hit(PADDR_I, IDX_FIELD_DRIVE_CTRL);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0]           rf_clk_sync;
    logic                 rf_clk_prev;
    logic [1:0]           ext_sync;
    logic [1:0]           above_sync;
    logic                 rf_tick;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rf_clk_sync <= 2'b00;
            rf_clk_prev <= 1'b0;
            ext_sync    <= 2'b00;
            above_sync  <= 2'b00;
        end else begin
            rf_clk_sync <= {rf_clk_sync[0], CLK_RF_I};
            rf_clk_prev <= rf_clk_sync[1];
            ext_sync    <= {ext_sync[0], EXT_FIELD_RAW_I};
            above_sync  <= {above_sync[0], RX_ABOVE_SETPOINT_I};
        end
    end

    // 13.56 MHz rising edge seen from the fast clock
    assign rf_tick = rf_clk_sync[1] && !rf_clk_prev;

    // ****************************************
    // External field filter
    // ****************************************
    // Level must stand steady this long; short detector glitches are dropped
    logic [7:0]           ext_count;
    logic                 ext_field;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ext_count <= 8'h00;
            ext_field <= 1'b0;
        end else if (ext_sync[1] == ext_field) begin
            ext_count <= 8'h00;
        end else if (ext_count == 8'(EXT_FILTER_LEN - 1)) begin
            ext_count <= 8'h00;
            ext_field <= ext_sync[1];
        end else begin
            ext_count <= ext_count + 8'h01;
        end
    end

    // ****************************************
    // Status capture
    // ****************************************
    logic [2:0]           trx_phase;
    logic [3:0]           power_control_step;
    logic                 rf_clock_lock_ok;
    logic                 crc_ok;
    logic                 own_field_on;
    logic                 rx_armed;
    logic                 tx_busy;
    logic                 rx_busy;
    logic                 next_crc_ok;

    // Only the low CRC_W bits carry the running check-sum
    always_comb begin
        if (CRC_INVERTED_I) begin
            next_crc_ok = (CRC_VALUE_I[CRC_W-1:0] == CRC_RESIDUE[CRC_W-1:0]);
        end else begin
            next_crc_ok = (CRC_VALUE_I[CRC_W-1:0] == '0);
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            trx_phase          <= PHASE_IDLE;
            power_control_step <= 4'h0;
            rf_clock_lock_ok   <= 1'b0;
            crc_ok             <= 1'b0;
            own_field_on       <= 1'b0;
            rx_armed           <= 1'b0;
            tx_busy            <= 1'b0;
            rx_busy            <= 1'b0;
        end else begin
            trx_phase          <= TRX_PHASE_I;
            power_control_step <= POWER_STEP_I;
            rf_clock_lock_ok   <= RF_ON_I && RF_FREQ_OK_I && PLL_LOCKED_I;
            crc_ok             <= next_crc_ok;
            own_field_on       <= DRIVERS_ON_I;
            rx_armed           <= RX_DECODER_READY_I;
            tx_busy            <= TX_ENCODER_BUSY_I;
            rx_busy            <= RX_DECODER_BUSY_I;
        end
    end

    // ****************************************
    // Peer-mode fault cause
    // ****************************************
    logic [2:0]           peer_mode_fault_code;
    logic                 fault_legal;
    logic                 drive_request_set;

    assign fault_legal       = PEER_FAULT_VALID_I && (PEER_FAULT_CODE_I >= FAULT_FIRST)
                            && (PEER_FAULT_CODE_I <= FAULT_LAST);
    assign drive_request_set = wr_drive && PWDATA_I[FD_REQUEST_BIT];

    // A fault arriving with the clearing write wins, so it is never lost
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            peer_mode_fault_code <= FAULT_NONE;
        end else if (fault_legal) begin
            peer_mode_fault_code <= PEER_FAULT_CODE_I;
        end else if (drive_request_set) begin
            peer_mode_fault_code <= FAULT_NONE;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            FIELD_DRIVER_ON_REQUEST_O <= 1'b0;
        end else if (wr_drive) begin
            FIELD_DRIVER_ON_REQUEST_O <= PWDATA_I[FD_REQUEST_BIT];
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [1:0]           gain_setpoint_sel;
    logic [9:0]           gain_period_count;
    logic                 static_gain_source;
    logic                 fixed_gain_choice;
    logic                 gain_loop_on;
    logic [9:0]           reader_static_gain;
    logic [9:0]           card_static_gain;
    logic                 static_gain_load;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            gain_setpoint_sel  <= SETPOINT_RESET;
            gain_period_count  <= PERIOD_RESET;
            static_gain_source <= 1'b0;
            fixed_gain_choice  <= 1'b0;
            gain_loop_on       <= 1'b0;
        end else if (wr_cfg) begin
            gain_setpoint_sel  <= PWDATA_I[CF_SETPOINT_LSB +: 2];
            gain_period_count  <= PWDATA_I[CF_PERIOD_LSB +: PERIOD_W];
            static_gain_source <= PWDATA_I[CF_SOURCE_BIT];
            fixed_gain_choice  <= PWDATA_I[CF_CHOICE_BIT];
            gain_loop_on       <= PWDATA_I[CF_LOOP_ON_BIT];
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            reader_static_gain <= GAIN_RESET;
            card_static_gain   <= GAIN_RESET;
        end else if (wr_static) begin
            reader_static_gain <= PWDATA_I[SG_READER_LSB +: GAIN_W];
            card_static_gain   <= PWDATA_I[SG_CARD_LSB +: GAIN_W];
        end
    end

    // Load pulse lasts one cycle; the bit never reads back as 1
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            static_gain_load <= 1'b0;
        end else begin
            static_gain_load <= wr_cfg && PWDATA_I[CF_LOAD_BIT];
        end
    end

    assign GAIN_SETPOINT_SEL_O = gain_setpoint_sel;

    // ****************************************
    // Gain update period
    // ****************************************
    // Period below four is not guarded; the loop just runs faster
    logic [9:0]           period_count;
    logic                 period_done;

    assign period_done = rf_tick && (period_count == gain_period_count);

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            period_count <= PERIOD_RESET;
        end else if (!gain_loop_on || period_done) begin
            period_count <= PERIOD_RESET;
        end else if (rf_tick) begin
            period_count <= period_count + 10'h001;
        end
    end

    // ****************************************
    // Gain level and receive divider
    // ****************************************
    logic [9:0]           gain_level;
    logic [9:0]           selected_static;
    logic [9:0]           next_gain_level;

    assign selected_static = static_gain_source ? reader_static_gain : card_static_gain;

    always_comb begin
        next_gain_level = gain_level;
        if (static_gain_load) begin
            next_gain_level = selected_static;
        end else if (gain_loop_on && period_done) begin
            if (above_sync[1] && gain_level != GAIN_MAX) begin
                next_gain_level = gain_level + 10'h001;
            end else if (!above_sync[1] && gain_level != GAIN_RESET) begin
                next_gain_level = gain_level - 10'h001;
            end
        end else if (!gain_loop_on && !fixed_gain_choice) begin
            // Choice 0 only changes on load, so writing the choice bit moves nothing
            next_gain_level = gain_level;
        end else begin
            next_gain_level = gain_level;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            gain_level <= GAIN_RESET;
        end else begin
            gain_level <= next_gain_level;
        end
    end

    assign RX_DIVIDER_O = gain_level;

    // ****************************************
    // Read path
    // ****************************************
    logic [31:0]          status_word;
    logic [31:0]          config_word;
    logic [31:0]          static_word;
    logic [31:0]          drive_word;
    logic [31:0]          next_rdata;

    always_comb begin
        status_word = WORD_ZERO;
        status_word[ST_PHASE_LSB +: 3]    = trx_phase;
        status_word[ST_STEP_LSB +: 4]     = power_control_step;
        status_word[ST_LOCK_BIT]          = rf_clock_lock_ok;
        status_word[ST_CRC_OK_BIT]        = crc_ok;
        status_word[ST_OWN_FIELD_BIT]     = own_field_on;
        status_word[ST_EXT_FIELD_BIT]     = ext_field;
        status_word[ST_FAULT_LSB +: 3]    = peer_mode_fault_code;
        status_word[ST_RX_ARMED_BIT]      = rx_armed;
        status_word[ST_TX_BUSY_BIT]       = tx_busy;
        status_word[ST_RX_BUSY_BIT]       = rx_busy;
        status_word[ST_GAIN_LSB +: GAIN_W] = gain_level;
        config_word = WORD_ZERO;
        config_word[CF_SETPOINT_LSB +: 2]  = gain_setpoint_sel;
        config_word[CF_PERIOD_LSB +: PERIOD_W] = gain_period_count;
        config_word[CF_SOURCE_BIT]         = static_gain_source;
        config_word[CF_CHOICE_BIT]         = fixed_gain_choice;
        config_word[CF_LOOP_ON_BIT]        = gain_loop_on;
        static_word = WORD_ZERO;
        static_word[SG_READER_LSB +: GAIN_W] = reader_static_gain;
        static_word[SG_CARD_LSB +: GAIN_W]   = card_static_gain;
        drive_word = WORD_ZERO;
        drive_word[FD_REQUEST_BIT]         = FIELD_DRIVER_ON_REQUEST_O;
    end

    always_comb begin
        next_rdata = WORD_ZERO;
        if (hit(PADDR_I, IDX_RF_LINK_STATUS)) begin
            next_rdata = status_word;
        end else if (hit(PADDR_I, IDX_GAIN_CONTROL_CONFIG)) begin
            next_rdata = config_word;
        end else if (hit(PADDR_I, IDX_STATIC_GAIN)) begin
            next_rdata = static_word;
        end else if (hit(PADDR_I, IDX_FIELD_DRIVE_CTRL)) begin
            next_rdata = drive_word;
        end
    end

    // Data captured in setup so the access phase sees a flip-flop
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            PRDATA_O  <= WORD_ZERO;
            PSLVERR_O <= 1'b0;
        end else if (setup_phase) begin
            PRDATA_O  <= PWRITE_I ? WORD_ZERO : next_rdata;
            PSLVERR_O <= !mapped;
        end else if (!PSEL_I) begin
            PSLVERR_O <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: verif/rf_gain_chk.sv */
// Assertion checker for the Rf_link_status and gain register bank.
// Assumes it sees only the top ports; mirrors config writes itself.
`timescale 1ns/100ps
`default_nettype none
module rf_gain_chk
    import rf_gain_pkg::*;
(
    input wire logic        CLK_I,
    input wire logic        RST_B_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic [2:0]  TRX_PHASE_I,
    input wire logic        RF_ON_I,
    input wire logic        RF_FREQ_OK_I,
    input wire logic        PLL_LOCKED_I,
    input wire logic [1:0]  GAIN_SETPOINT_SEL_O,
    input wire logic [9:0]  RX_DIVIDER_O,
    input wire logic        FIELD_DRIVER_ON_REQUEST_O
);
    // ****
    // Mirror of written fields
    // ****
    wire logic   acc = PSEL_I && PENABLE_I;
    wire logic   wr = acc && PWRITE_I;
    wire logic   rd_st = acc && !PWRITE_I && PADDR_I == 12'h074;
    wire logic   ld0 = wr && PADDR_I == 12'h078 && PWDATA_I[2];
    logic [19:0] sg;
    logic [1:0]  sp;
    logic        loop_on;
    logic [2:0]  ld;
    logic [9:0]  ld_val;
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            sg      <= '0;
            sp      <= '0;
            loop_on <= 1'h0;
            ld      <= '0;
        end else begin
            ld <= {ld[1:0], ld0};
            if (wr && PADDR_I == 12'h07C)
                sg <= PWDATA_I[19:0];
            if (wr && PADDR_I == 12'h078) begin
                sp      <= PWDATA_I[15:14];
                loop_on <= PWDATA_I[0];
            end
        end
    end
    // Load pulse may land one or two edges late, so the window spans both
    always_ff @(posedge CLK_I)
        if (ld0)
            ld_val <= PWDATA_I[3] ? sg[19:10] : sg[9:0];
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    property p_ready; acc |-> PREADY_O; endproperty
    a_ready: assert property (p_ready) else $error("access without ready");
    property p_err; acc |-> PSLVERR_O == !(PADDR_I inside {12'h074, 12'h078, 12'h07C, 12'h0C0}); endproperty
    a_err: assert property (p_err) else $error("wrong error response");
    property p_stat; rd_st |-> PRDATA_O[31:27] == 5'h00 && PRDATA_O[26:24] == $past(TRX_PHASE_I, 2); endproperty
    a_stat: assert property (p_stat) else $error("bad phase field");
    property p_lock; rd_st |-> PRDATA_O[19] == $past(RF_ON_I && RF_FREQ_OK_I && PLL_LOCKED_I, 2); endproperty
    a_lock: assert property (p_lock) else $error("bad lock bit");
    property p_sp; $stable(sp) |-> GAIN_SETPOINT_SEL_O == sp; endproperty
    a_sp: assert property (p_sp) else $error("set point output differs");
    property p_load; ld0 && !PWDATA_I[0] |-> ##[2:3] RX_DIVIDER_O == ld_val; endproperty
    a_load: assert property (p_load) else $error("static gain not loaded");
    property p_hold; !loop_on && ld == 3'h0 && !ld0 |=> $stable(RX_DIVIDER_O); endproperty
    a_hold: assert property (p_hold) else $error("divider moved in fixed mode");
    property p_step; loop_on && ld == 3'h0 && !ld0 |=> 10'(RX_DIVIDER_O - $past(RX_DIVIDER_O)) inside {10'h000, 10'h001, 10'h3FF}; endproperty
    a_step: assert property (p_step) else $error("gain step too large");
    property p_drv;
        wr && PADDR_I == 12'h0C0 |=> FIELD_DRIVER_ON_REQUEST_O == $past(PWDATA_I[0]);
    endproperty
    a_drv: assert property (p_drv) else $error("driver request not updated");
    c_load: cover property (ld[1]);
    c_err: cover property (acc && PSLVERR_O);
    c_step: cover property (loop_on && $changed(RX_DIVIDER_O));
endmodule
bind rf_link_status_gain_ctrl rf_gain_chk i_rf_gain_chk (.*);
`default_nettype wire

/* File: verif/rf_field_model.sv */
// Far-side model: free-running carrier clock and receive level comparator.
// Assumes the bench chooses the comparator level.
`timescale 1ns/100ps
`default_nettype none
module rf_field_model (
    input  wire logic above_i,
    output logic      clk_rf_o,
    output logic      cmp_o
);
    // Carrier runs free, unrelated in phase to the bus clock
    initial begin
        clk_rf_o = 1'h0;
        forever #36.9 clk_rf_o = ~clk_rf_o;
    end
    assign cmp_o = above_i;
endmodule
`default_nettype wire

/* File: verif/rf_link_status_gain_ctrl_tb_top.sv */
// Self-checking bench for the Rf_link_status and gain register bank.
// Assumes the checker is bound in and the field model drives the RF pins.
`timescale 1ns/100ps
`default_nettype none
module rf_link_status_gain_ctrl_tb_top
    import rf_gain_pkg::*;
;
    logic        clk = 1'h0;
    logic        rst_b = 1'h0;
    logic        psel = 1'h0;
    logic        pen = 1'h0;
    logic        pwr = 1'h0;
    logic [11:0] pa = '0;
    logic [31:0] pwd = '0;
    logic [13:0] st = '0;
    logic [15:0] crc = '0;
    logic [2:0]  fc = '0;
    logic        inv = 1'h0, ext = 1'h0, fv = 1'h0, above = 1'h0, eo;
    logic [31:0] r, exp;
    logic [10:0] pat [8] = '{11'h000, 11'h7FF, 11'h7EF, 11'h1C5, 11'h63A, 11'h0F0, 11'h555, 11'h2AA};
    wire logic [31:0] prd;
    wire logic [9:0]  div;
    wire logic [1:0]  spo;
    wire logic        prdy, perr, clk_rf, cmp, fdr;
    int          err_total = 0, compares = 0, cyc = 0;
    rf_field_model i_rf_field_model (.above_i(above), .clk_rf_o(clk_rf), .cmp_o(cmp));
    rf_link_status_gain_ctrl #(.CRC_RESIDUE(16'hA5A5), .EXT_FILTER_LEN(2)) i_rf_link_status_gain_ctrl (
        .CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
        .TRX_PHASE_I(st[13:11]), .POWER_STEP_I(st[10:7]), .RF_ON_I(st[6]),
        .RF_FREQ_OK_I(st[5]), .PLL_LOCKED_I(st[4]), .CRC_VALUE_I(crc), .CRC_INVERTED_I(inv),
        .DRIVERS_ON_I(st[3]), .EXT_FIELD_RAW_I(ext), .PEER_FAULT_VALID_I(fv),
        .PEER_FAULT_CODE_I(fc), .RX_DECODER_READY_I(st[2]), .TX_ENCODER_BUSY_I(st[1]),
        .RX_DECODER_BUSY_I(st[0]), .CLK_RF_I(clk_rf), .RX_ABOVE_SETPOINT_I(cmp),
        .GAIN_SETPOINT_SEL_O(spo), .RX_DIVIDER_O(div), .FIELD_DRIVER_ON_REQUEST_O(fdr));
    // ****
    // Clock, timeout and bus tasks
    // ****
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("Counts: %0d mismatches, %0d compares", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        compares++;
        if (got !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, e);
        end
    endtask
    // Request held unchanged until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (prdy !== 1'h1);
        r = prd;
        eo = perr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    // Settling gap so status flops reflect the latest inputs
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        repeat (3) @(posedge clk);
        apb(1'h0, a, WORD_ZERO);
        chk(r & m, e);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'h1;
        rd(12'h074, '1, 32'h0004_0000);
        rd(12'h078, '1, WORD_ZERO);
        rd(12'h07C, '1, WORD_ZERO);
        rd(12'h100, '1, WORD_ZERO);
        chk(eo, 1'h1);
        for (int k = 0; k < 8; k++) begin
            st <= {k[2:0], pat[k]};
            rd(12'h074, 32'hFFFF_FC00, {5'h00, k[2:0], pat[k][10:7], &pat[k][6:4], 1'h1, pat[k][3], 4'h0, pat[k][2:0], 10'h000});
        end
        st <= '0;
        for (int k = 0; k < 4; k++) begin
            crc <= (k[1] ? 16'hA5A5 : 16'h0000) ^ k[0];
            inv <= k[1];
            rd(12'h074, 32'h0004_0000, k[0] ? WORD_ZERO : 32'h0004_0000);
        end
        for (int k = 0; k < 2; k++) begin
            ext <= !k[0];
            repeat (12) @(posedge clk);
            rd(12'h074, 32'h0001_0000, k[0] ? WORD_ZERO : 32'h0001_0000);
        end
        for (int k = 1; k < 8; k++) begin
            fv <= 1'h1;
            fc <= k[2:0];
            @(posedge clk);
            fv <= 1'h0;
            rd(12'h074, 32'h0000_E000, k < 5 ? {16'h0000, k[2:0], 13'h0000} : WORD_ZERO);
            wr(12'h0C0, 32'h0000_0001);
            rd(12'h074, 32'h0000_E000, WORD_ZERO);
        end
        chk(fdr, 1'h1);
        wr(12'h07C, '1);
        rd(12'h07C, '1, 32'h000F_FFFF);
        wr(12'h07C, {12'h000, 10'h2B3, 10'h155});
        wr(12'h078, 32'h0000_4004);
        rd(12'h074, 32'h0000_03FF, 32'h0000_0155);
        rd(12'h078, '1, 32'h0000_4000);
        chk(spo, 2'h1);
        wr(12'h078, 32'h0000_800C);
        rd(12'h074, 32'h0000_03FF, 32'h0000_02B3);
        chk(div, 10'h2B3);
        wr(12'h078, 32'h0000_8002);
        rd(12'h074, 32'h0000_03FF, 32'h0000_02B3);
        wr(12'h078, 32'h0000_8000);
        rd(12'h074, 32'h0000_03FF, 32'h0000_02B3);
        wr(12'h07C, 32'h0000_03FC);
        wr(12'h078, 32'h0000_0044);
        above <= 1'h1;
        wr(12'h078, 32'h0000_0041);
        repeat (40) @(posedge clk_rf);
        rd(12'h074, 32'h0000_03FF, 32'h0000_03FF);
        above <= 1'h0;
        repeat (100) @(posedge clk_rf);
        rd(12'h074, 32'hFFFF_FC00, WORD_ZERO);
        chk(r[9:0] >= 10'h3EA && r[9:0] <= 10'h3EC, 1'h1);
        wr(12'h078, 32'h0000_0040);
        rd(12'h074, 32'hFFFF_FC00, WORD_ZERO);
        exp = r & 32'h0000_03FF;
        above <= 1'h1;
        repeat (200) @(posedge clk);
        rd(12'h074, 32'h0000_03FF, exp);
        above <= 1'h0;
        wr(12'h07C, 32'h0000_0002);
        wr(12'h078, 32'h0000_0044);
        wr(12'h078, 32'h0000_0041);
        repeat (30) @(posedge clk_rf);
        rd(12'h074, 32'h0000_03FF, WORD_ZERO);
        end_of_test();
    end
endmodule
`default_nettype wire
